/* File: rtl/dsr_pkg.sv */
// constants for the sync and stream routing configuration registers
package dsr_pkg;

  // register selects on the host expansion interface
  localparam logic [0:0] DSR_IDX_SYNC = 1'h0;
  localparam logic [0:0] DSR_IDX_MUX = 1'h1;

  // host data word
  localparam int DSR_HOST_W = 16;
  localparam int DSR_REG_W = 8;

  // sync configuration register fields
  localparam int DSR_CLK_SRC_LSB = 0;
  localparam int DSR_CLK_SRC_W = 2;
  localparam int DSR_IN_START_BIT = 4;
  localparam int DSR_OUT_START_BIT = 5;
  localparam int DSR_EVT_KIND_BIT = 6;
  localparam int DSR_SLAVE_BIT = 7;
  localparam logic [7:0] DSR_SYNC_WMASK = 8'hf3;
  localparam logic [7:0] DSR_SYNC_RST = 8'h00;

  // mux configuration register fields
  localparam int DSR_PAIR_LSB = 0;
  localparam int DSR_PAIR_W = 2;
  localparam int DSR_IN_STREAM_BIT = 4;
  localparam int DSR_OUT_STREAM_BIT = 5;
  localparam logic [7:0] DSR_MUX_WMASK = 8'h33;
  localparam logic [7:0] DSR_MUX_RST = 8'h00;

  // sample clock source codes
  localparam logic [1:0] DSR_SRC_GEN = 2'h0;
  localparam logic [1:0] DSR_SRC_EXT = 2'h1;
  localparam logic [1:0] DSR_SRC_TMR0 = 2'h2;
  localparam logic [1:0] DSR_SRC_TMR1 = 2'h3;

  // default stream width
  localparam int DSR_STREAM_W = 32;

  // acquisition start states
  typedef enum logic [1:0] {
    DSR_IDLE,
    DSR_ARMED,
    DSR_RUN
  } dsr_acq_e;

endpackage

/* File: rtl/dsr_sync_route_cfg.sv */
// sync source, start qualification and stream routing configuration
`timescale 1ns/100ps
module dsr_sync_route_cfg
  import dsr_pkg::*;
#(
  parameter int STREAM_W = DSR_STREAM_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [0:0] host_reg_sel,
  input wire logic [DSR_HOST_W-1:0] host_wdata,
  output logic [DSR_HOST_W-1:0] host_rdata,
  input wire logic onboard_freq_generator,
  input wire logic ext_sample_clock,
  input wire logic host_timer_pin0,
  input wire logic host_timer_pin1,
  output logic sample_clock,
  output logic [1:0] sample_clock_source,
  input wire logic input_acq_go,
  input wire logic output_acq_go,
  input wire logic input_mode_active,
  input wire logic output_mode_active,
  input wire logic input_ext_start_pin_n,
  input wire logic output_ext_start_pin_n,
  output logic sync_out_n_o,
  output logic sync_out_oe,
  output logic input_acq_start,
  output logic input_acq_armed,
  output logic input_acq_running,
  output logic output_acq_start,
  output logic output_acq_armed,
  output logic output_acq_running,
  output logic [3:0] analog_pair_select,
  input wire logic [STREAM_W-1:0] conv_in_data,
  input wire logic conv_in_valid,
  input wire logic [STREAM_W-1:0] ext_parallel_in,
  input wire logic ext_parallel_in_valid,
  output logic [STREAM_W-1:0] in_fifo_data,
  output logic in_fifo_valid,
  input wire logic [STREAM_W-1:0] out_fifo_data,
  input wire logic out_fifo_valid,
  output logic [STREAM_W-1:0] conv_out_data,
  output logic conv_out_valid,
  output logic [STREAM_W-1:0] ext_parallel_out,
  output logic ext_parallel_out_valid
);

  logic [DSR_REG_W-1:0] sync_cfg_q;
  logic [DSR_REG_W-1:0] mux_cfg_q;
  logic [3:0] clk_pin_s1_q;
  logic [3:0] clk_pin_s2_q;
  logic [1:0] start_s1_q;
  logic [1:0] start_s2_q;
  logic [1:0] start_prev_q;
  logic [1:0] start_evt;
  dsr_acq_e in_state_q;
  dsr_acq_e out_state_q;
  logic evt_kind_edge;
  logic slave_mode;
  logic in_ext;
  logic out_ext;
  logic wr_en;

  // start event from a synchronised active-low pin
  function automatic logic start_event(input logic now_lvl, input logic prev_lvl,
                                       input logic edge_kind);
    start_event = edge_kind ? (prev_lvl & ~now_lvl) : ~now_lvl;
  endfunction

  // next state of one start controller
  function automatic dsr_acq_e acq_next(input dsr_acq_e cur, input logic go,
                                       input logic active, input logic ext_sel,
                                       input logic evt);
    acq_next = cur;
    unique case (cur)
      DSR_IDLE: begin
        if (go && active) begin
          acq_next = ext_sel ? DSR_ARMED : DSR_RUN;
        end
      end
      DSR_ARMED: begin
        if (!go || !active) begin
          acq_next = DSR_IDLE;
        end else if (evt) begin
          acq_next = DSR_RUN;
        end
      end
      DSR_RUN: begin
        if (!go) begin
          acq_next = DSR_IDLE;
        end
      end
    endcase
  endfunction

  assign wr_en = host_cs & host_wr;
  assign evt_kind_edge = sync_cfg_q[DSR_EVT_KIND_BIT];
  assign slave_mode = sync_cfg_q[DSR_SLAVE_BIT];
  // a slave always waits for the master's sync
  assign in_ext = sync_cfg_q[DSR_IN_START_BIT] | slave_mode;
  assign out_ext = sync_cfg_q[DSR_OUT_START_BIT] | slave_mode;

  // host register writes, reserved bits held at zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync_cfg_q <= DSR_SYNC_RST;
      mux_cfg_q <= DSR_MUX_RST;
    end else if (wr_en) begin
      if (host_reg_sel == DSR_IDX_SYNC) begin
        sync_cfg_q <= host_wdata[DSR_REG_W-1:0] & DSR_SYNC_WMASK;
      end else begin
        mux_cfg_q <= host_wdata[DSR_REG_W-1:0] & DSR_MUX_WMASK;
      end
    end
  end

  // host read data, upper byte zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      host_rdata <= '0;
    end else if (host_cs && host_rd) begin
      if (host_reg_sel == DSR_IDX_SYNC) begin
        host_rdata <= {8'h00, sync_cfg_q};
      end else begin
        host_rdata <= {8'h00, mux_cfg_q};
      end
    end
  end

  // clock source pins synchronised
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clk_pin_s1_q <= 4'h0;
      clk_pin_s2_q <= 4'h0;
    end else begin
      clk_pin_s1_q <= {host_timer_pin1, host_timer_pin0, ext_sample_clock,
                       onboard_freq_generator};
      clk_pin_s2_q <= clk_pin_s1_q;
    end
  end

  // sample clock source selection
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sample_clock <= 1'b0;
      sample_clock_source <= DSR_SRC_GEN;
    end else begin
      sample_clock_source <= sync_cfg_q[DSR_CLK_SRC_LSB +: DSR_CLK_SRC_W];
      unique case (sync_cfg_q[DSR_CLK_SRC_LSB +: DSR_CLK_SRC_W])
        DSR_SRC_GEN: sample_clock <= clk_pin_s2_q[0];
        DSR_SRC_EXT: sample_clock <= clk_pin_s2_q[1];
        DSR_SRC_TMR0: sample_clock <= clk_pin_s2_q[2];
        DSR_SRC_TMR1: sample_clock <= clk_pin_s2_q[3];
      endcase
    end
  end

  // start pins synchronised, idle high
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      start_s1_q <= 2'h3;
      start_s2_q <= 2'h3;
      start_prev_q <= 2'h3;
    end else begin
      start_s1_q <= {output_ext_start_pin_n, input_ext_start_pin_n};
      start_s2_q <= start_s1_q;
      start_prev_q <= start_s2_q;
    end
  end

  assign start_evt[0] = start_event(start_s2_q[0], start_prev_q[0], evt_kind_edge);
  assign start_evt[1] = start_event(start_s2_q[1], start_prev_q[1], evt_kind_edge);

  // input start controller
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      in_state_q <= DSR_IDLE;
    end else begin
      in_state_q <= acq_next(in_state_q, input_acq_go, input_mode_active, in_ext,
                             start_evt[0]);
    end
  end

  // output start controller
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      out_state_q <= DSR_IDLE;
    end else begin
      out_state_q <= acq_next(out_state_q, output_acq_go, output_mode_active, out_ext,
                              start_evt[1]);
    end
  end

  // start pulses on entry to run
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      input_acq_start <= 1'b0;
      output_acq_start <= 1'b0;
    end else begin
      input_acq_start <= (in_state_q != DSR_RUN) &&
        (acq_next(in_state_q, input_acq_go, input_mode_active, in_ext, start_evt[0])
         == DSR_RUN);
      output_acq_start <= (out_state_q != DSR_RUN) &&
        (acq_next(out_state_q, output_acq_go, output_mode_active, out_ext, start_evt[1])
         == DSR_RUN);
    end
  end

  assign input_acq_armed = (in_state_q == DSR_ARMED);
  assign input_acq_running = (in_state_q == DSR_RUN);
  assign output_acq_armed = (out_state_q == DSR_ARMED);
  assign output_acq_running = (out_state_q == DSR_RUN);

  // master drives sync low while either side runs
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync_out_n_o <= 1'b1;
      sync_out_oe <= 1'b0;
    end else begin
      sync_out_oe <= ~slave_mode;
      sync_out_n_o <= ~(~slave_mode & (input_acq_running | output_acq_running));
    end
  end

  // analog pair one-hot select
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      analog_pair_select <= 4'h1;
    end else begin
      analog_pair_select <= 4'h1 << mux_cfg_q[DSR_PAIR_LSB +: DSR_PAIR_W];
    end
  end

  // input stream selector
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      in_fifo_data <= '0;
      in_fifo_valid <= 1'b0;
    end else if (mux_cfg_q[DSR_IN_STREAM_BIT]) begin
      in_fifo_data <= ext_parallel_in;
      in_fifo_valid <= ext_parallel_in_valid;
    end else begin
      in_fifo_data <= conv_in_data;
      in_fifo_valid <= conv_in_valid;
    end
  end

  // output stream selector
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      conv_out_data <= '0;
      conv_out_valid <= 1'b0;
      ext_parallel_out <= '0;
      ext_parallel_out_valid <= 1'b0;
    end else begin
      conv_out_valid <= out_fifo_valid & ~mux_cfg_q[DSR_OUT_STREAM_BIT];
      ext_parallel_out_valid <= out_fifo_valid & mux_cfg_q[DSR_OUT_STREAM_BIT];
      if (mux_cfg_q[DSR_OUT_STREAM_BIT]) begin
        ext_parallel_out <= out_fifo_data;
      end else begin
        conv_out_data <= out_fifo_data;
      end
    end
  end

  // checks
  sequence go_in_mode_s;
    input_acq_go && input_mode_active && in_state_q == DSR_IDLE;
  endsequence

  sequence out_go_in_mode_s;
    output_acq_go && output_mode_active && out_state_q == DSR_IDLE;
  endsequence

  soft_in_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
    go_in_mode_s and !in_ext |=> input_acq_running ##0 $rose(input_acq_start))
    else $error("input did not start at once");

  ext_in_arm_a: assert property (@(posedge core_clk) disable iff (!rstn)
    go_in_mode_s and in_ext |=> input_acq_armed && !input_acq_start)
    else $error("input did not arm");

  soft_out_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
    out_go_in_mode_s and !out_ext |=> output_acq_running && output_acq_start)
    else $error("output did not start at once");

  ext_out_wait_a: assert property (@(posedge core_clk) disable iff (!rstn)
    output_acq_armed && output_acq_go && output_mode_active && !start_evt[1]
    |=> output_acq_armed)
    else $error("output left armed without event");

  level_event_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !evt_kind_edge && input_acq_armed && input_acq_go && input_mode_active
    && !start_s2_q[0] |=> input_acq_running)
    else $error("low level did not start input");

  edge_only_a: assert property (@(posedge core_clk) disable iff (!rstn)
    evt_kind_edge && $stable(evt_kind_edge) && !start_s2_q[0] && !start_prev_q[0]
    |-> !start_evt[0])
    else $error("held low taken as edge");

  master_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !slave_mode && input_acq_running ##1 !slave_mode |-> sync_out_oe && !sync_out_n_o)
    else $error("master not driving sync");

  slave_release_a: assert property (@(posedge core_clk) disable iff (!rstn)
    slave_mode |=> !sync_out_oe)
    else $error("slave drives sync");

  pair_select_a: assert property (@(posedge core_clk) disable iff (!rstn)
    1'b1 |=> analog_pair_select[$past(mux_cfg_q[1:0])] && $onehot(analog_pair_select))
    else $error("wrong analog pair");

  in_stream_a: assert property (@(posedge core_clk) disable iff (!rstn)
    1'b1 |=> in_fifo_data == ($past(mux_cfg_q[DSR_IN_STREAM_BIT]) ?
      $past(ext_parallel_in) : $past(conv_in_data)))
    else $error("input stream misrouted");

  out_stream_a: assert property (@(posedge core_clk) disable iff (!rstn)
    out_fifo_valid |=> (conv_out_valid ^ ext_parallel_out_valid)
    && (ext_parallel_out_valid == $past(mux_cfg_q[DSR_OUT_STREAM_BIT])))
    else $error("output stream misrouted");

  readback_a: assert property (@(posedge core_clk) disable iff (!rstn)
    host_cs && host_wr && !host_rd ##1 host_cs && host_rd && !host_wr
    && host_reg_sel == $past(host_reg_sel)
    |=> host_rdata[15:8] == 8'h00 && host_rdata[7:0] == ($past(host_wdata[7:0], 2)
        & (($past(host_reg_sel) == DSR_IDX_SYNC) ? DSR_SYNC_WMASK : DSR_MUX_WMASK)))
    else $error("register readback mismatch");

  reset_clear_a: assert property (@(posedge core_clk)
    !rstn |=> sync_cfg_q == 8'h00 && mux_cfg_q == 8'h00)
    else $error("reset did not clear selects");

  source_pick_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $stable(sync_cfg_q[1:0]) ##1 $stable(sync_cfg_q[1:0])
    |-> sample_clock == $past(clk_pin_s2_q[sync_cfg_q[1:0]]))
    else $error("wrong sample clock source");

  idle_no_event_a: assert property (@(posedge core_clk) disable iff (!rstn)
    in_state_q == DSR_IDLE && in_ext |=> !input_acq_running && !input_acq_start)
    else $error("event taken while idle");

endmodule

/* File: tb/dsr_host_model.sv */
// host processor model driving the register access strobes
`timescale 1ns/100ps
module dsr_host_model
  import dsr_pkg::*;
(
  input wire logic core_clk,
  output logic host_cs,
  output logic host_wr,
  output logic host_rd,
  output logic [0:0] host_reg_sel,
  output logic [DSR_HOST_W-1:0] host_wdata,
  input wire logic [DSR_HOST_W-1:0] host_rdata
);
  initial begin
    host_cs = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_reg_sel = 1'h0;
    host_wdata = 16'h0000;
  end

  // one write cycle, held until the taking edge
  task automatic wr_reg(input logic [0:0] sel, input logic [15:0] val);
    @(posedge core_clk);
    host_cs <= 1'b1;
    host_wr <= 1'b1;
    host_reg_sel <= sel;
    host_wdata <= val; // register in the low byte
    @(posedge core_clk);
    host_cs <= 1'b0;
    host_wr <= 1'b0;
    host_wdata <= ~val;
  endtask

  // one read cycle, data taken after the read edge
  task automatic rd_reg(input logic [0:0] sel, output logic [15:0] val);
    @(posedge core_clk);
    host_cs <= 1'b1;
    host_rd <= 1'b1;
    host_reg_sel <= sel;
    @(posedge core_clk);
    host_cs <= 1'b0;
    host_rd <= 1'b0;
    #1;
    val = host_rdata; // low byte read back
  endtask

  // write then read back on the very next edge
  task automatic wr_rd_reg(input logic [0:0] sel, input logic [15:0] wval,
                           output logic [15:0] rval);
    @(posedge core_clk);
    host_cs <= 1'b1;
    host_wr <= 1'b1;
    host_reg_sel <= sel;
    host_wdata <= wval; // register in the low byte
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_rd <= 1'b1;
    host_wdata <= ~wval;
    @(posedge core_clk);
    host_cs <= 1'b0;
    host_rd <= 1'b0;
    #1;
    rval = host_rdata; // new value read back
  endtask
endmodule

/* File: tb/dsr_sync_route_cfg_bench.sv */
// self-checking bench for the sync and stream routing configuration block
`timescale 1ns/100ps
module dsr_sync_route_cfg_bench
  import dsr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn;
  logic host_cs, host_wr, host_rd;
  logic [0:0] host_reg_sel;
  logic [DSR_HOST_W-1:0] host_wdata, host_rdata, rd_val;
  logic gen_clk, ext_clk, tmr0, tmr1, sample_clock;
  logic [1:0] sample_clock_source;
  logic in_go, out_go, in_mode, out_mode, in_pin_n, out_pin_n, sync_out_n_o, sync_out_oe;
  logic in_start, in_armed, in_running, out_start, out_armed, out_running;
  logic [3:0] analog_pair_select;
  logic [DSR_STREAM_W-1:0] conv_in_data, ext_in, in_fifo_data, out_fifo_data, conv_out, ext_out;
  logic conv_in_valid, ext_in_valid, in_fifo_valid, out_fifo_valid, conv_out_valid, ext_out_valid;
  int fails = 0;
  int n_tests = 0;

  always #10 core_clk = ~core_clk;

  dsr_host_model u_dsr_host_model (.core_clk(core_clk), .host_cs(host_cs), .host_wr(host_wr),
    .host_rd(host_rd), .host_reg_sel(host_reg_sel), .host_wdata(host_wdata),
    .host_rdata(host_rdata));

  dsr_sync_route_cfg u_dsr_sync_route_cfg (.core_clk(core_clk), .rstn(rstn),
    .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd), .host_reg_sel(host_reg_sel),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .onboard_freq_generator(gen_clk),
    .ext_sample_clock(ext_clk), .host_timer_pin0(tmr0), .host_timer_pin1(tmr1),
    .sample_clock(sample_clock), .sample_clock_source(sample_clock_source),
    .input_acq_go(in_go), .output_acq_go(out_go), .input_mode_active(in_mode),
    .output_mode_active(out_mode), .input_ext_start_pin_n(in_pin_n),
    .output_ext_start_pin_n(out_pin_n), .sync_out_n_o(sync_out_n_o),
    .sync_out_oe(sync_out_oe), .input_acq_start(in_start), .input_acq_armed(in_armed),
    .input_acq_running(in_running), .output_acq_start(out_start),
    .output_acq_armed(out_armed), .output_acq_running(out_running),
    .analog_pair_select(analog_pair_select), .conv_in_data(conv_in_data),
    .conv_in_valid(conv_in_valid), .ext_parallel_in(ext_in),
    .ext_parallel_in_valid(ext_in_valid), .in_fifo_data(in_fifo_data),
    .in_fifo_valid(in_fifo_valid), .out_fifo_data(out_fifo_data),
    .out_fifo_valid(out_fifo_valid), .conv_out_data(conv_out),
    .conv_out_valid(conv_out_valid), .ext_parallel_out(ext_out),
    .ext_parallel_out_valid(ext_out_valid));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // bounded wait for a controller to enter run
  task automatic wait_run(input logic out_side);
    int i;
    for (i = 0; i < 12; i++) begin
      cyc(1);
      if ((out_side ? out_running : in_running) === 1'b1) return;
    end
    fails++;
    $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask

  task automatic set_ctl(input logic go, input logic pin_n);
    @(posedge core_clk);
    in_go <= go;
    out_go <= go;
    in_pin_n <= pin_n;
    out_pin_n <= pin_n;
  endtask

  initial begin
    rstn = 1'b0;
    {gen_clk, ext_clk, tmr0, tmr1} = 4'h0;
    {in_go, out_go, in_mode, out_mode} = 4'h0;
    {in_pin_n, out_pin_n} = 2'b11;
    {conv_in_data, ext_in, out_fifo_data} = '0;
    {conv_in_valid, ext_in_valid, out_fifo_valid} = 3'b000;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(2);
    chk(sync_out_oe, 1'b1);
    chk(analog_pair_select, 4'h1);
    u_dsr_host_model.rd_reg(DSR_IDX_SYNC, rd_val);
    chk(rd_val, 16'h0000);
    u_dsr_host_model.wr_reg(DSR_IDX_SYNC, 16'hffff);
    u_dsr_host_model.rd_reg(DSR_IDX_SYNC, rd_val);
    chk(rd_val, 16'h00f3);
    chk(sync_out_oe, 1'b0);
    u_dsr_host_model.wr_reg(DSR_IDX_MUX, 16'hffff);
    u_dsr_host_model.rd_reg(DSR_IDX_MUX, rd_val);
    chk(rd_val, 16'h0033);
    u_dsr_host_model.wr_rd_reg(DSR_IDX_SYNC, 16'h5a35, rd_val);
    chk(rd_val, 16'h0031);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    u_dsr_host_model.rd_reg(DSR_IDX_SYNC, rd_val);
    chk(rd_val, 16'h0000);
    u_dsr_host_model.rd_reg(DSR_IDX_MUX, rd_val);
    chk(rd_val, 16'h0000);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      u_dsr_host_model.wr_reg(DSR_IDX_SYNC, 16'(s));
      @(posedge core_clk);
      {tmr1, tmr0, ext_clk, gen_clk} <= 4'h1 << s;
      cyc(5);
      chk(sample_clock, 1'b1);
      chk(sample_clock_source, s[1:0]);
      @(posedge core_clk);
      {tmr1, tmr0, ext_clk, gen_clk} <= ~(4'h1 << s);
      cyc(5);
      chk(sample_clock, 1'b0);
    end
    $display("test clock source done");
    for (int m = 0; m < 4; m++) begin
      u_dsr_host_model.wr_reg(DSR_IDX_MUX, 16'(m) | (16'(m) << 4));
      @(posedge core_clk);
      conv_in_data <= 32'h0a0a0000 + m;
      ext_in <= 32'h0e0e0000 + m;
      out_fifo_data <= 32'h0d0d0000 + m;
      {conv_in_valid, ext_in_valid, out_fifo_valid} <= 3'b111;
      cyc(3);
      chk(analog_pair_select, 4'h1 << m);
      chk(in_fifo_data, (m[0] ? 32'h0e0e0000 : 32'h0a0a0000) + m);
      chk(in_fifo_valid, 1'b1);
      chk({conv_out_valid, ext_out_valid}, m[1] ? 2'b01 : 2'b10);
      chk(m[1] ? ext_out : conv_out, 32'h0d0d0000 + m);
    end
    $display("test routing done");
    u_dsr_host_model.wr_reg(DSR_IDX_SYNC, 16'h0000);
    @(posedge core_clk);
    in_mode <= 1'b1;
    out_mode <= 1'b1;
    set_ctl(1'b1, 1'b1);
    cyc(1);
    chk({in_start, out_start}, 2'b11);
    cyc(1);
    chk({in_running, out_running}, 2'b11);
    chk(sync_out_n_o, 1'b0);
    set_ctl(1'b0, 1'b0);
    cyc(2);
    chk({in_running, out_running}, 2'b00);
    $display("test software start done");
    u_dsr_host_model.wr_reg(DSR_IDX_SYNC, 16'h0030);
    set_ctl(1'b0, 1'b1);
    cyc(5);
    chk({in_armed, in_running, out_armed, out_running}, 4'h0);
    set_ctl(1'b1, 1'b1);
    cyc(4);
    chk({in_armed, in_running, out_armed, out_running}, 4'ha);
    set_ctl(1'b1, 1'b0);
    wait_run(1'b0);
    wait_run(1'b1);
    set_ctl(1'b0, 1'b1);
    $display("test level start done");
    u_dsr_host_model.wr_reg(DSR_IDX_SYNC, 16'h0070);
    set_ctl(1'b0, 1'b0);
    cyc(4);
    set_ctl(1'b1, 1'b0);
    cyc(6);
    chk({in_armed, in_running, out_armed, out_running}, 4'ha);
    set_ctl(1'b1, 1'b1);
    cyc(3);
    set_ctl(1'b1, 1'b0);
    wait_run(1'b0);
    wait_run(1'b1);
    set_ctl(1'b0, 1'b1);
    $display("test edge start done");
    u_dsr_host_model.wr_reg(DSR_IDX_SYNC, 16'h0080);
    set_ctl(1'b1, 1'b1);
    cyc(3);
    chk(sync_out_oe, 1'b0);
    chk({in_armed, out_armed}, 2'b11);
    set_ctl(1'b1, 1'b0);
    wait_run(1'b0);
    wait_run(1'b1);
    $display("test slave start done");
    complete_run();
  end
endmodule
